// >>> hw/rst_seq_pkg.sv
/*
 * Constants, types and register map of the system reset sequencer.
 * Assumes a single 100 MHz clock that is already running in every state.
 */
// Notes on behaviour
// - Latch outside low reset pin, clock-synchronised.
// - Drive pin 512 cycles after outside releases.
// - Internal request drives pin 512+, while present.
// - Then float pin ten cycles, then sample.
// - High starts reset processing; low repeats drive.
// - Postpone recognition until bus cycle end; code also takes it once BUS_WAIT_MAX cycles pass with no end.
// - Recognise at bus end, abort processing; code also recognises at the BUS_WAIT_MAX limit.
// - Synchronised request asserts internal master reset.
// - Power-on: hold pin until lock plus 512.
// - Modules reset after four master reset cycles.
// - Integration pins inactive while pin asserted.
// - Port pins come out as high-impedance inputs.
// - Master reset: abort, clear traces, supervisor, mask 7.
// - Master reset clears vector table base.
// - On master release, sample breakpoint first.
// - Load stack pointer, then program counter, then fetch.
// - Vectors from internal RAM or boot chip select.
// - One cause bit per source, several together.
// - Cause register updated at pin release only.
// - Either breakpoint low enables background debug.

package rst_seq_pkg;

	localparam int unsigned PULSE_CYCLES    = 512;
	localparam int unsigned FLOAT_CYCLES    = 10;
	localparam int unsigned MRST_MIN_CYCLES = 4;
	localparam int unsigned CNT_W           = 10;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CAUSE  = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_VBASE  = 8'h0C;

	localparam int unsigned CTRL_SW_RST = 0;

	localparam int unsigned CAUSE_W   = 4;
	localparam int unsigned CAUSE_EXT = 0;
	localparam int unsigned CAUSE_INT = 1;
	localparam int unsigned CAUSE_SW  = 2;
	localparam int unsigned CAUSE_POR = 3;

	localparam logic [2:0]  IPL_RESET   = 3'h7;
	localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_ISP_OFS = 32'h0000_0000;
	localparam logic [31:0] VEC_PC_OFS  = 32'h0000_0004;

	typedef enum logic [2:0] {
		ST_POR      = 3'h0,
		ST_EXT_WAIT = 3'h1,
		ST_DRIVE    = 3'h2,
		ST_FLOAT    = 3'h3,
		ST_RUN      = 3'h4
	} seq_state_t;

	typedef enum logic [2:0] {
		BT_IDLE = 3'h0,
		BT_BREAKPOINT_INPUT = 3'h1,
		BT_ISP  = 3'h2,
		BT_PC   = 3'h3,
		BT_GO   = 3'h4
	} boot_state_t;

	typedef struct packed {
		logic       trace_bit_high;
		logic       trace_bit_low;
		logic       supervisor;
		logic [2:0] ipl;
	} cpu_sr_t;

	typedef struct packed {
		logic        valid;
		logic        boot_chip_select;
		logic [31:0] addr;
	} vec_req_t;

endpackage : rst_seq_pkg

// >>> hw/system_reset_sequencer.sv
/*
 * System reset sequencer: shared reset pin stretching and retest, master
 * reset, module reset, reset cause register and the reset vector fetch.
 * Assumes all inputs are synchronous to CLK and the pin has a pull-up.
 */
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module system_reset_sequencer #(
	parameter int unsigned EXT_MIN_CYCLES = 2,
	parameter int unsigned BUS_WAIT_MAX   = 64
) (
	// Clock and power-on reset
	input  wire logic                 CLK,
	input  wire logic                 RST_B,
	input  wire logic                 PLL_LOCK,
	// Shared reset pin
	input  wire logic                 RESET_PIN_I,
	output logic                      RESET_PIN_O,
	output logic                      RESET_PIN_OE,
	// Reset sources and bus timing
	input  wire logic                 INT_RST_REQ,
	input  wire logic                 BUS_CYCLE_END,
	// Reset outputs to the system
	output logic                      MASTER_RESET,
	output logic                      MODULE_RESET,
	output logic                      ABORT_EXEC,
	output logic                      SIM_PINS_INACTIVE,
	output logic                      PORT_PINS_HIZ,
	// Processor start-up
	input  wire logic                 BREAKPOINT_INPUT_INT_B,
	input  wire logic                 BREAKPOINT_INPUT_EXT_B,
	input  wire logic                 BOOT_FROM_RAM,
	output rst_seq_pkg::vec_req_t     VEC_REQ,
	input  wire logic                 VEC_ACK,
	input  wire logic [31:0]          VEC_DATA,
	output rst_seq_pkg::cpu_sr_t      CPU_SR,
	output logic [31:0]               STACK_PTR,
	output logic [31:0]               PROG_CNT,
	output logic                      BDM_ENABLE,
	output logic                      FIRST_FETCH,
	// Register port
	input  wire logic [7:0]           ADDR,
	input  wire logic [31:0]          WDATA,
	input  wire logic                 WR,
	input  wire logic                 RD,
	output logic [31:0]               RDATA
);

	rst_seq_pkg::seq_state_t           state_r;
	rst_seq_pkg::seq_state_t           state_nxt;
	rst_seq_pkg::boot_state_t          boot_r;
	logic [rst_seq_pkg::CNT_W-1:0]     cnt_r;
	logic [rst_seq_pkg::CNT_W-1:0]     cnt_nxt;
	logic [15:0]                       ext_cnt_r;
	logic [15:0]                       wait_cnt_r;
	logic                              ext_latch_r;
	logic                              sw_req_r;
	logic                              mrst_r;
	logic [2:0]                        mcnt_r;
	logic [rst_seq_pkg::CAUSE_W-1:0]   pend_r;
	logic [rst_seq_pkg::CAUSE_W-1:0]   cause_r;
	logic [31:0]                       vbase_r;
	logic                              req_pend;
	logic                              go;
	logic                              release_ev;
	logic                              pulse_end;
	logic                              float_end;
	logic                              hold_req;

	assign req_pend  = ext_latch_r | INT_RST_REQ | sw_req_r;
	// A bus cycle in flight finishes, or BUS_WAIT_MAX cycles pass, before reset takes hold
	assign go        = (state_r == rst_seq_pkg::ST_RUN) && req_pend &&
		(BUS_CYCLE_END || wait_cnt_r == 16'(BUS_WAIT_MAX));
	assign pulse_end = cnt_r == rst_seq_pkg::CNT_W'(rst_seq_pkg::PULSE_CYCLES - 1);
	assign float_end = cnt_r == rst_seq_pkg::CNT_W'(rst_seq_pkg::FLOAT_CYCLES - 1);
	assign hold_req  = INT_RST_REQ | sw_req_r;
	assign release_ev = (state_r == rst_seq_pkg::ST_FLOAT) && float_end && RESET_PIN_I;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 1'b1;
		case (state_r)
			rst_seq_pkg::ST_POR: begin
				if (!PLL_LOCK) begin
					cnt_nxt = '0;
				end else if (pulse_end) begin
					state_nxt = rst_seq_pkg::ST_FLOAT;
					cnt_nxt   = '0;
				end
			end
			rst_seq_pkg::ST_EXT_WAIT: begin
				cnt_nxt = '0;
				if (RESET_PIN_I) begin
					state_nxt = rst_seq_pkg::ST_DRIVE;
				end
			end
			rst_seq_pkg::ST_DRIVE: begin
				if (pulse_end) begin
					if (hold_req) begin
						cnt_nxt = cnt_r;
					end else begin
						state_nxt = rst_seq_pkg::ST_FLOAT;
						cnt_nxt   = '0;
					end
				end
			end
			rst_seq_pkg::ST_FLOAT: begin
				if (float_end) begin
					cnt_nxt   = '0;
					state_nxt = RESET_PIN_I ? rst_seq_pkg::ST_RUN : rst_seq_pkg::ST_DRIVE;
				end
			end
			rst_seq_pkg::ST_RUN: begin
				cnt_nxt = '0;
				if (go) begin
					state_nxt = ext_latch_r ? rst_seq_pkg::ST_EXT_WAIT : rst_seq_pkg::ST_DRIVE;
				end
			end
			default: begin
				state_nxt = rst_seq_pkg::ST_POR;
				cnt_nxt   = '0;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_r <= rst_seq_pkg::ST_POR;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// Only ever pulls low, so others can share the line
	assign RESET_PIN_O = 1'b0;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RESET_PIN_OE      <= 1'b1;
			SIM_PINS_INACTIVE <= 1'b1;
		end else begin
			RESET_PIN_OE      <= state_nxt == rst_seq_pkg::ST_POR || state_nxt == rst_seq_pkg::ST_DRIVE;
			SIM_PINS_INACTIVE <= state_nxt != rst_seq_pkg::ST_RUN;
		end
	end

	// Low samples are counted only while nobody inside drives the pin
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ext_cnt_r   <= '0;
			ext_latch_r <= 1'b0;
		end else if (state_r != rst_seq_pkg::ST_RUN) begin
			ext_cnt_r   <= '0;
			ext_latch_r <= 1'b0;
		end else if (RESET_PIN_I) begin
			ext_cnt_r <= '0;
		end else if (ext_cnt_r == 16'(EXT_MIN_CYCLES - 1)) begin
			ext_latch_r <= 1'b1;
		end else begin
			ext_cnt_r <= ext_cnt_r + 1'b1;
		end
	end

	// Stands in for the bus monitor when a cycle never ends
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wait_cnt_r <= '0;
		end else if (!req_pend || go) begin
			wait_cnt_r <= '0;
		end else if (wait_cnt_r != 16'(BUS_WAIT_MAX)) begin
			wait_cnt_r <= wait_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mrst_r <= 1'b1;
			mcnt_r <= '0;
		end else begin
			if (go) begin
				mrst_r <= 1'b1;
			end else if (release_ev) begin
				mrst_r <= 1'b0;
			end
			if (!mrst_r) begin
				mcnt_r <= '0;
			end else if (mcnt_r != 3'(rst_seq_pkg::MRST_MIN_CYCLES)) begin
				mcnt_r <= mcnt_r + 1'b1;
			end
		end
	end

	assign MASTER_RESET  = mrst_r;
	assign ABORT_EXEC    = mrst_r;
	assign PORT_PINS_HIZ = mrst_r;
	assign MODULE_RESET  = mrst_r && mcnt_r == 3'(rst_seq_pkg::MRST_MIN_CYCLES);

	// Causes gather while reset runs and show only once the pin lets go
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pend_r  <= rst_seq_pkg::CAUSE_W'(1) << rst_seq_pkg::CAUSE_POR;
			cause_r <= '0;
		end else if (release_ev) begin
			cause_r <= pend_r;
			// An internal request raised at the release edge is kept for the next reset
			pend_r  <= rst_seq_pkg::CAUSE_W'(INT_RST_REQ) << rst_seq_pkg::CAUSE_INT;
		end else begin
			// A software request written at the take edge still counts as a cause
			if (go || state_r == rst_seq_pkg::ST_DRIVE) begin
				pend_r[rst_seq_pkg::CAUSE_EXT] <= pend_r[rst_seq_pkg::CAUSE_EXT] | ext_latch_r;
				pend_r[rst_seq_pkg::CAUSE_SW]  <= pend_r[rst_seq_pkg::CAUSE_SW] | sw_req_r;
			end
			if (INT_RST_REQ) begin
				pend_r[rst_seq_pkg::CAUSE_INT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sw_req_r <= 1'b0;
		end else if (WR && ADDR == rst_seq_pkg::OFS_CTRL && WDATA[rst_seq_pkg::CTRL_SW_RST]) begin
			sw_req_r <= 1'b1;
		end else if (state_r == rst_seq_pkg::ST_DRIVE && pulse_end) begin
			sw_req_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			vbase_r <= rst_seq_pkg::VBASE_RESET;
			CPU_SR  <= '0;
		end else if (mrst_r) begin
			vbase_r               <= rst_seq_pkg::VBASE_RESET;
			CPU_SR.trace_bit_high <= 1'b0;
			CPU_SR.trace_bit_low  <= 1'b0;
			CPU_SR.supervisor     <= 1'b1;
			CPU_SR.ipl            <= rst_seq_pkg::IPL_RESET;
		end else if (WR && ADDR == rst_seq_pkg::OFS_VBASE) begin
			vbase_r <= WDATA;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= '0;
		end else if (RD) begin
			case (ADDR)
				rst_seq_pkg::OFS_CTRL:   RDATA <= 32'(sw_req_r);
				rst_seq_pkg::OFS_CAUSE:  RDATA <= 32'(cause_r);
				rst_seq_pkg::OFS_STATUS: RDATA <= 32'({BDM_ENABLE, PLL_LOCK, mrst_r, state_r});
				rst_seq_pkg::OFS_VBASE:  RDATA <= vbase_r;
				default:                 RDATA <= '0;
			endcase
		end else begin
			RDATA <= '0;
		end
	end

	// Start-up after master reset negates
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			boot_r      <= rst_seq_pkg::BT_IDLE;
			BDM_ENABLE  <= 1'b0;
			VEC_REQ     <= '0;
			STACK_PTR   <= '0;
			PROG_CNT    <= '0;
			FIRST_FETCH <= 1'b0;
		end else if (mrst_r) begin
			boot_r      <= release_ev ? rst_seq_pkg::BT_BREAKPOINT_INPUT : rst_seq_pkg::BT_IDLE;
			VEC_REQ     <= '0;
			FIRST_FETCH <= 1'b0;
		end else begin
			FIRST_FETCH <= 1'b0;
			case (boot_r)
				rst_seq_pkg::BT_BREAKPOINT_INPUT: begin
					BDM_ENABLE               <= !BREAKPOINT_INPUT_INT_B || !BREAKPOINT_INPUT_EXT_B;
					VEC_REQ.valid            <= 1'b1;
					VEC_REQ.boot_chip_select <= !BOOT_FROM_RAM;
					VEC_REQ.addr             <= vbase_r + rst_seq_pkg::VEC_ISP_OFS;
					boot_r                   <= rst_seq_pkg::BT_ISP;
				end
				rst_seq_pkg::BT_ISP: begin
					if (VEC_ACK) begin
						STACK_PTR    <= VEC_DATA;
						VEC_REQ.addr <= vbase_r + rst_seq_pkg::VEC_PC_OFS;
						boot_r       <= rst_seq_pkg::BT_PC;
					end
				end
				rst_seq_pkg::BT_PC: begin
					if (VEC_ACK) begin
						PROG_CNT <= VEC_DATA;
						VEC_REQ  <= '0;
						boot_r   <= rst_seq_pkg::BT_GO;
					end
				end
				rst_seq_pkg::BT_GO: begin
					FIRST_FETCH <= 1'b1;
					boot_r      <= rst_seq_pkg::BT_IDLE;
				end
				default: begin
					boot_r <= rst_seq_pkg::BT_IDLE;
				end
			endcase
		end
	end

	// Checking
	logic [rst_seq_pkg::CNT_W:0] oe_run_r;
	logic                        por_seen_r;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			oe_run_r   <= '0;
			por_seen_r <= 1'b0;
		end else begin
			oe_run_r <= !RESET_PIN_OE ? '0 : (&oe_run_r ? oe_run_r : oe_run_r + 1'b1);
			if (state_r != rst_seq_pkg::ST_POR) begin
				por_seen_r <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	chk_pin_low_only: assert property (RESET_PIN_O == 1'b0)
		else $error("reset pin driven high");
	chk_drive_min_len: assert property ($fell(RESET_PIN_OE) && por_seen_r |->
		oe_run_r >= (rst_seq_pkg::CNT_W + 1)'(rst_seq_pkg::PULSE_CYCLES))
		else $error("reset pin drive shorter than 512 cycles");
	chk_float_window: assert property ($fell(RESET_PIN_OE) |->
		(!RESET_PIN_OE)[*8] ##1 !RESET_PIN_OE ##1 !RESET_PIN_OE)
		else $error("float window shorter than ten cycles");
	chk_lock_hold: assert property (state_r == rst_seq_pkg::ST_POR && !PLL_LOCK |=>
		RESET_PIN_OE && MASTER_RESET)
		else $error("pin released before lock");
	chk_module_delay: assert property ($rose(MODULE_RESET) |->
		$past(MASTER_RESET, 4) && $past(MASTER_RESET, 1))
		else $error("modules reset too early");
	chk_cause_release: assert property (!$stable(cause_r) |-> $past(release_ev))
		else $error("cause register changed outside release");
	chk_sr_init: assert property (MASTER_RESET |=>
		CPU_SR.ipl == rst_seq_pkg::IPL_RESET && CPU_SR.supervisor &&
		!CPU_SR.trace_bit_low && !CPU_SR.trace_bit_high)
		else $error("status not initialised under master reset");
	chk_vbase_clear: assert property (MASTER_RESET ##1 RD && ADDR == rst_seq_pkg::OFS_VBASE |=>
		RDATA == rst_seq_pkg::VBASE_RESET)
		else $error("vector base not cleared");
	chk_go_bus_end: assert property (go && !BUS_CYCLE_END |->
		wait_cnt_r == 16'(BUS_WAIT_MAX))
		else $error("reset taken mid bus cycle");
	chk_breakpoint_input_sample: assert property (boot_r == rst_seq_pkg::BT_BREAKPOINT_INPUT && !mrst_r |=>
		BDM_ENABLE == ($past(!BREAKPOINT_INPUT_INT_B) || $past(!BREAKPOINT_INPUT_EXT_B)))
		else $error("breakpoint mode sampled wrong");

	cov_ext_reset: cover property (ext_latch_r && go);
	cov_int_reset: cover property (state_r == rst_seq_pkg::ST_DRIVE && pulse_end && INT_RST_REQ);
	cov_retest:    cover property (state_r == rst_seq_pkg::ST_FLOAT && float_end && !RESET_PIN_I);
	cov_boot_done: cover property (FIRST_FETCH);

endmodule : system_reset_sequencer

`default_nettype wire

// >>> test/reset_line_partner.sv
/*
 * Model of the outside devices that share the reset line, together with the line's pull-up.
 * Assumes the bench says when an outside device pulls the line low and for how long.
 */
`timescale 1ns/10ps
`default_nettype none

module reset_line_partner (
	// Device side of the pin
	input  wire logic dev_o,
	input  wire logic dev_oe,
	// Outside pull-down request
	input  wire logic hold_low,
	// Resolved line level
	output logic      pin_level
);
	// Wired-AND: any party may pull low, the pull-up wins when all let go
	assign pin_level = ((dev_oe && !dev_o) || hold_low) ? 1'b0 : 1'b1;
endmodule : reset_line_partner

`default_nettype wire

// >>> test/tb_top.sv
/*
 * Self-checking bench of the system reset sequencer: power-on, internal, software and outside resets.
 * Assumes the reset line partner model and a vector memory that answers one cycle after a request.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic                  clk, rst_b, pll, int_req, bus_end, breakpoint_input_i, breakpoint_input_e, boot_ram, vec_ack, wr, rd;
	logic                  hold_low, pin, pin_o, pin_oe, mreset, mod_rst, abort_x, sim_ina, port_hiz, bdm, ffetch;
	logic [31:0]           vec_data, wdata, rdata, sp, pc, rd_val;
	logic [7:0]            addr;
	rst_seq_pkg::vec_req_t vec_req;
	rst_seq_pkg::cpu_sr_t  cpu_sr;
	int                    miscompares, comparisons, drv, flt, runs;

	system_reset_sequencer #(.EXT_MIN_CYCLES(2), .BUS_WAIT_MAX(64)) dut_u (
		.CLK(clk), .RST_B(rst_b), .PLL_LOCK(pll), .RESET_PIN_I(pin), .RESET_PIN_O(pin_o),
		.RESET_PIN_OE(pin_oe), .INT_RST_REQ(int_req), .BUS_CYCLE_END(bus_end), .MASTER_RESET(mreset),
		.MODULE_RESET(mod_rst), .ABORT_EXEC(abort_x), .SIM_PINS_INACTIVE(sim_ina), .PORT_PINS_HIZ(port_hiz),
		.BREAKPOINT_INPUT_INT_B(breakpoint_input_i), .BREAKPOINT_INPUT_EXT_B(breakpoint_input_e), .BOOT_FROM_RAM(boot_ram), .VEC_REQ(vec_req),
		.VEC_ACK(vec_ack), .VEC_DATA(vec_data), .CPU_SR(cpu_sr), .STACK_PTR(sp), .PROG_CNT(pc),
		.BDM_ENABLE(bdm), .FIRST_FETCH(ffetch), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));

	reset_line_partner line_u (.dev_o(pin_o), .dev_oe(pin_oe), .hold_low(hold_low), .pin_level(pin));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Vector memory: word at an address reads as that address with a marker in the top byte
	always @(posedge clk) begin
		vec_ack <= vec_req.valid && !vec_ack;
		vec_data <= 32'hA000_0000 | vec_req.addr;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd

	// Follows one reset from master reset rise to first fetch; keeps the last drive run and float length
	task automatic observe(input logic exp_bdm);
		int   n;
		int   k;
		logic prev;
		n = 0;
		k = 0;
		drv = 0;
		flt = 0;
		runs = 0;
		prev = 1'b0;
		// Sampling starts at the call edge so a drive run launched there is counted
		while (n < 4000 && !(k > 0 && mreset === 1'b0)) begin
			#1;
			n++;
			if (mreset === 1'b1) begin
				k++;
				if (pin_oe === 1'b1) begin
					if (prev !== 1'b1) begin
						drv = 0;
						runs++;
					end
					drv++;
					flt = 0;
				end else if (runs > 0) begin
					flt++;
				end
				prev = pin_oe;
			end
			if (k == 5) begin
				check("module reset", 32'h1, {31'h0, mod_rst});
				check("status init", 32'h0F, {26'h0, cpu_sr});
				check("pins and abort", 32'h7, {29'h0, abort_x, sim_ina, port_hiz});
				check("no fetch in reset", 32'h0, {31'h0, vec_req.valid});
				check("pin drive value", 32'h0, {31'h0, pin_o});
			end
			@(posedge clk);
		end
		check("master reset seen", 32'h1, {31'h0, k > 0});
		for (n = 0; n < 100 && ffetch !== 1'b1; n++) begin
			@(posedge clk);
			#1;
			if (vec_req.valid === 1'b1) check("boot select", {31'h0, !boot_ram}, {31'h0, vec_req.boot_chip_select});
		end
		check("first fetch", 32'h1, {31'h0, ffetch});
		check("stack pointer", 32'hA000_0000 | rst_seq_pkg::VEC_ISP_OFS, sp);
		check("program counter", 32'hA000_0000 | rst_seq_pkg::VEC_PC_OFS, pc);
		check("debug enable", {31'h0, exp_bdm}, {31'h0, bdm});
	endtask : observe

	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("watchdog expired");
		wrap_up();
	end

	initial begin
		{rst_b, pll, int_req, wr, rd, hold_low, boot_ram, vec_ack} = 8'h00;
		{bus_end, breakpoint_input_i, breakpoint_input_e} = 3'h7;
		{addr, wdata, vec_data} = 72'h0;
		miscompares = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		// Power-on with a late lock
		repeat (50) @(posedge clk);
		check("pin held before lock", 32'h1, {31'h0, pin_oe});
		pll <= 1'b1;
		observe(1'b0);
		check("lock drive span", 32'h1, {31'h0, drv >= 512 && drv <= 516});
		check("por float", 32'd10, flt);
		reg_rd(rst_seq_pkg::OFS_CAUSE, rd_val);
		check("cause por", 32'h8, rd_val);
		reg_rd(rst_seq_pkg::OFS_STATUS, rd_val);
		check("status after power on", 32'h14, rd_val);
		$display("test power_on done");
		// Short internal request with no bus cycle end, taken when the wait limit runs out
		reg_wr(rst_seq_pkg::OFS_VBASE, 32'h400);
		reg_rd(rst_seq_pkg::OFS_VBASE, rd_val);
		check("vbase write", 32'h400, rd_val);
		reg_rd(8'h10, rd_val);
		check("unmapped read", 32'h0, rd_val);
		@(posedge clk);
		bus_end <= 1'b0;
		int_req <= 1'b1;
		breakpoint_input_i <= 1'b0;
		boot_ram <= 1'b1;
		repeat (20) @(posedge clk);
		#1 check("postponed", 32'h0, {31'h0, mreset});
		// Taken at the edge where the wait count has reached BUS_WAIT_MAX, 65 edges after the request
		repeat (44) @(posedge clk);
		#1 check("still postponed", 32'h0, {31'h0, mreset});
		@(posedge clk);
		bus_end <= 1'b1;
		int_req <= 1'b0;
		observe(1'b1);
		check("int drive", 32'd512, drv);
		check("int float", 32'd10, flt);
		reg_rd(rst_seq_pkg::OFS_CAUSE, rd_val);
		check("cause int", 32'h2, rd_val);
		reg_rd(rst_seq_pkg::OFS_VBASE, rd_val);
		check("vbase cleared", rst_seq_pkg::VBASE_RESET, rd_val);
		$display("test internal done");
		// Software and long internal request together
		@(posedge clk);
		breakpoint_input_i <= 1'b1;
		boot_ram <= 1'b0;
		int_req <= 1'b1;
		addr <= rst_seq_pkg::OFS_CTRL;
		wdata <= 32'h1;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		repeat (20) @(posedge clk);
		reg_rd(rst_seq_pkg::OFS_CTRL, rd_val);
		check("sw request pending", 32'h1, rd_val);
		reg_rd(rst_seq_pkg::OFS_CAUSE, rd_val);
		check("cause held in reset", 32'h2, rd_val);
		reg_wr(rst_seq_pkg::OFS_VBASE, 32'h55);
		reg_rd(rst_seq_pkg::OFS_VBASE, rd_val);
		check("vbase in reset", 32'h0, rd_val);
		repeat (670) @(posedge clk);
		#1 check("drive while requested", 32'h1, {31'h0, pin_oe});
		@(posedge clk);
		int_req <= 1'b0;
		observe(1'b0);
		check("sw float", 32'd10, flt);
		reg_rd(rst_seq_pkg::OFS_CAUSE, rd_val);
		check("cause int and sw", 32'h6, rd_val);
		reg_rd(rst_seq_pkg::OFS_VBASE, rd_val);
		check("vbase write in reset", 32'h0, rd_val);
		$display("test software done");
		// Outside reset, then the line is held again during the float
		@(posedge clk);
		breakpoint_input_e <= 1'b0;
		hold_low <= 1'b1;
		repeat (6) @(posedge clk);
		#1 check("ext latched", 32'h2, {30'h0, mreset, pin_oe});
		@(posedge clk);
		hold_low <= 1'b0;
		fork
			observe(1'b1);
			begin
				@(negedge pin_oe);
				@(posedge clk);
				hold_low <= 1'b1;
				repeat (15) @(posedge clk);
				hold_low <= 1'b0;
			end
		join
		check("ext runs", 32'd2, runs);
		check("ext drive", 32'd512, drv);
		check("ext float", 32'd10, flt);
		reg_rd(rst_seq_pkg::OFS_CAUSE, rd_val);
		check("cause ext", 32'h1, rd_val);
		$display("test outside done");
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
